// ==== src/source_qualify_status_report.sv ====
// Source qualification, input fault handling, status pins and register 00
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: On supply attach, sink 75mA for 32ms; start converter if input valid.
// R2: Input under weak threshold in window: sink off, wait 2s, retry.
// R3: Failed qualification pulses both status outputs 128us and updates fields.
// R4: Retries repeat forever until another source or a valid window end.
// R5: Weak input in normal run: converter off, battery path on, pulse, update.
// R6: Good supply again clears state and fault fields, resumes normal run.
// R7: Over-voltage in normal run: converter off, battery path on, pulse, update.
// R8: Over-voltage removed clears state and fault fields, resumes normal run.
// R9: Charge-status pulled low while charging only if indicator enable is 1.
// R10: Charge done, disabled or other normal states leave output released.
// R11: Event pulses appear whatever the indicator enable bit holds.
// R12: Host event output mirrors the charge-status output exactly.
// R13: Each listed event gives a 128us pulse, then release, on both.
// R14: Writing one to bit 7 kicks watchdog; bit self-clears, reads zero.
// R15: State field bits 6:4 codes: none, ready, charging, done, fault.
// R16: Fault field bits 2:0 codes as listed, 101 supply fault.
// R17: Any access starts 30s watchdog; expiry reloads defaults, restarts safety.
// R18: Pulse, window and retry lengths come from clock-derived cycle counts.
module source_qualify_status_report
(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              nrst,
	// Analog comparators and charger status (asynchronous to core_clk)
	input  wire srcq_pkg::sense_t  sense,
	// One-cycle event strobes from charger logic on core_clk
	input  wire srcq_pkg::events_t events,
	// Register port
	input  wire srcq_pkg::reg_req_t reg_req,
	output logic [7:0]             reg_rdata,
	// Indicator enable from the control register
	input  wire logic              stat_enable,
	// Power stage
	output srcq_pkg::power_t       power,
	// Open-drain status pins, enable high pulls low
	output logic                   charge_status_o,
	output logic                   charge_status_oe,
	output logic                   host_event_o,
	output logic                   host_event_oe,
	// Supply status field and housekeeping
	output srcq_pkg::supply_status_t supply_status,
	output logic                   load_defaults,
	output logic                   safety_restart
);

	// ==========================================================
	// State
	srcq_pkg::srcq_state_t s;
	srcq_pkg::srcq_state_t next_s;

	// Counter width for the sized load casts below
	localparam int unsigned CNT_W = srcq_pkg::CNT_W;

	logic ev_pulse;
	logic present_s;
	logic weak_ok;
	logic ovp_s;
	logic other_s;
	logic access;
	logic wdog_expire;
	logic charging_s;
	logic done_s;
	logic wr_reg00;
	logic kick;

	// Comparator and status levels after the second synchroniser stage
	assign present_s = s.sync2[5];
	assign weak_ok   = s.sync2[4];
	assign ovp_s     = s.sync2[3];
	assign other_s   = s.sync2[2];
	assign charging_s = s.sync2[1];
	assign done_s    = s.sync2[0];
	assign access    = reg_req.wr | reg_req.rd;
	assign wdog_expire = s.wdog_run && (s.wdog == '0);
	// Host writes to register 00 and the watchdog kick carried in them
	assign wr_reg00  = reg_req.wr && (reg_req.addr == srcq_pkg::REG_CHARGE_STATE_AND_FAULT);
	assign kick      = wr_reg00 && reg_req.wdata[srcq_pkg::KICK_BIT]; // R14

	// ==========================================================
	// Behaviour notes
	// Every pin level passes two flops, so each reaction lags its pin by three edges.
	// A pin pulse shorter than one cycle may be missed; the comparators are expected
	// to carry their own hysteresis and the charger status levels to be slow.
	// Register reads show the fields one edge after they change, so a read in the
	// cycle of a change still returns the old value.
	// The timers count single clock cycles: one wide counter each was traded for
	// exact durations at the full clock rate, with no prescaler to drift from.
	// The sequencer never leaves the retry wait on a weak input alone; only the
	// wait running out or a fresh source on the other input restarts the window.
	// Removal of the supply overrides every sequencer step in the same cycle, except the fault code and pulse that step sets.

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		next_s = s;
		ev_pulse = 1'b0;
		next_s.load_defaults = 1'b0;
		// Two-flop synchronisers for every comparator and status pin; only the
		// second stage is read, so a metastable first stage never reaches a
		// decision
		next_s.sync1 = {sense.supply_present, sense.above_weak, sense.above_ovp,
			sense.other_source, sense.charging, sense.charge_done};
		next_s.sync2 = s.sync1;
		next_s.present_d = present_s;
		next_s.other_d = other_s;
		next_s.stat_en = stat_enable;
		if (s.timer != '0)
		begin
			next_s.timer = s.timer - 1'b1;
		end

		// Supply plug-in or removal is a status change
		if (present_s != s.present_d)
		begin
			ev_pulse = 1'b1; // R13
		end

		// Qualification sequencer: idle, test window, retry wait, run, input faults
		unique case (s.qstate)
			srcq_pkg::Q_IDLE:
			begin
				if (present_s)
				begin
					next_s.qstate = srcq_pkg::Q_WINDOW; // R1
					next_s.timer = CNT_W'(srcq_pkg::WINDOW_CYC - 1); // R18
				end
			end
			srcq_pkg::Q_WINDOW:
			begin
				if (!weak_ok)
				begin
					next_s.qstate = srcq_pkg::Q_RETRY; // R2
					next_s.timer = CNT_W'(srcq_pkg::RETRY_CYC - 1); // R18
					next_s.state_code = srcq_pkg::ST_FAULT; // R3
					next_s.fault_code = srcq_pkg::FLT_SUPPLY;
					next_s.supply_status = srcq_pkg::SUP_WEAK;
					ev_pulse = 1'b1; // R3
				end
				else if (s.timer == '0)
				begin
					if (!ovp_s)
					begin
						next_s.qstate = srcq_pkg::Q_RUN; // R1 R4
						next_s.state_code = srcq_pkg::ST_IN_READY;
						next_s.fault_code = srcq_pkg::FLT_NORMAL;
						next_s.supply_status = srcq_pkg::SUP_NORMAL;
					end
					else
					begin
						next_s.qstate = srcq_pkg::Q_OVP;
						next_s.state_code = srcq_pkg::ST_FAULT;
						next_s.fault_code = srcq_pkg::FLT_SUPPLY;
						next_s.supply_status = srcq_pkg::SUP_OVP;
						ev_pulse = 1'b1;
					end
				end
			end
			srcq_pkg::Q_RETRY:
			begin
				// A fresh source cuts the wait short
				if (s.timer == '0 || (other_s && !s.other_d))
				begin
					next_s.qstate = srcq_pkg::Q_WINDOW; // R4
					next_s.timer = CNT_W'(srcq_pkg::WINDOW_CYC - 1);
				end
			end
			srcq_pkg::Q_RUN:
			begin
				if (ovp_s)
				begin
					next_s.qstate = srcq_pkg::Q_OVP; // R7
					next_s.state_code = srcq_pkg::ST_FAULT;
					next_s.fault_code = srcq_pkg::FLT_SUPPLY;
					next_s.supply_status = srcq_pkg::SUP_OVP;
					ev_pulse = 1'b1; // R7
				end
				else if (!weak_ok)
				begin
					next_s.qstate = srcq_pkg::Q_WEAK; // R5
					next_s.state_code = srcq_pkg::ST_FAULT;
					next_s.fault_code = srcq_pkg::FLT_SUPPLY;
					next_s.supply_status = srcq_pkg::SUP_WEAK;
					ev_pulse = 1'b1; // R5
				end
				else
				begin
					// R15
					next_s.state_code = charging_s ? srcq_pkg::ST_CHARGING :
						(done_s ? srcq_pkg::ST_DONE : srcq_pkg::ST_IN_READY);
				end
			end
			srcq_pkg::Q_WEAK:
			begin
				if (weak_ok && !ovp_s)
				begin
					next_s.qstate = srcq_pkg::Q_RUN; // R6
					next_s.state_code = srcq_pkg::ST_IN_READY;
					next_s.fault_code = srcq_pkg::FLT_NORMAL; // R6
					next_s.supply_status = srcq_pkg::SUP_NORMAL;
				end
			end
			srcq_pkg::Q_OVP:
			begin
				if (!ovp_s)
				begin
					next_s.qstate = srcq_pkg::Q_RUN; // R8
					next_s.state_code = srcq_pkg::ST_IN_READY;
					next_s.fault_code = srcq_pkg::FLT_NORMAL; // R8
					next_s.supply_status = srcq_pkg::SUP_NORMAL;
				end
			end
			default:
			begin
				next_s.qstate = srcq_pkg::Q_IDLE;
			end
		endcase

		// Removal wins over the sequencer's state, timer, state code and supply status
		if (!present_s)
		begin
			next_s.qstate = srcq_pkg::Q_IDLE;
			next_s.timer = '0;
			next_s.state_code = srcq_pkg::ST_NO_SOURCE;
			next_s.supply_status = srcq_pkg::SUP_UVLO;
		end

		// Events from other charger blocks, later ones take the fault code
		// Sleep entry only pulses the pins; it leaves both codes alone
		if (events.safety_timer)
		begin
			next_s.fault_code = srcq_pkg::FLT_SAFETY; // R16
		end
		if (events.bat_temp)
		begin
			next_s.fault_code = srcq_pkg::FLT_BAT_TEMP; // R16
		end
		if (events.bat_fault)
		begin
			next_s.fault_code = srcq_pkg::FLT_BATTERY; // R16
		end
		if (events.thermal)
		begin
			next_s.fault_code = srcq_pkg::FLT_THERMAL; // R16
		end
		if (events.safety_timer | events.bat_temp | events.bat_fault | events.thermal)
		begin
			next_s.state_code = srcq_pkg::ST_FAULT;
		end
		if (|events)
		begin
			ev_pulse = 1'b1; // R13
		end

		// Watchdog: any access arms it, a kick reloads it
		if (wr_reg00)
		begin
			next_s.spare = reg_req.wdata[srcq_pkg::SPARE_BIT];
		end
		// Expiry is honoured in any bus cycle but a kick, so the count can never wrap
		if (access && (!s.wdog_run || kick))
		begin
			next_s.wdog_run = 1'b1; // R14 R17
			next_s.wdog = CNT_W'(srcq_pkg::WDOG_CYC - 1);
		end
		else if (wdog_expire)
		begin
			next_s.wdog_run = 1'b0; // R17
			next_s.load_defaults = 1'b1;
			next_s.spare = srcq_pkg::SPARE_RESET;
			next_s.fault_code = srcq_pkg::FLT_WATCHDOG;
			ev_pulse = 1'b1; // R13
		end
		else if (s.wdog_run)
		begin
			next_s.wdog = s.wdog - 1'b1;
		end

		// Event pulse stretcher; a new event restarts it
		// Events closer than one pulse merge, so the host sees one longer low period
		if (ev_pulse)
		begin
			next_s.pulse = 16'(srcq_pkg::PULSE_CYC); // R13 R18
		end
		else if (s.pulse != '0)
		begin
			next_s.pulse = s.pulse - 1'b1;
		end

		// Read data; kick bit always reads zero
		next_s.rdata = {1'b0, s.state_code, s.spare, s.fault_code}; // R14 R15 R16
	end

	// ==========================================================
	// State register
	// Reset gives no source, normal fault, supply below lockout, indicator enabled
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s <= '{qstate: srcq_pkg::Q_IDLE, state_code: srcq_pkg::ST_NO_SOURCE,
				fault_code: srcq_pkg::FLT_NORMAL, supply_status: srcq_pkg::SUP_UVLO,
				stat_en: srcq_pkg::STAT_EN_RESET, default: '0};
		end
		else
		begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	// Power stage decodes the sequencer state; sink and converter decode distinct
	// states, so they can never be on together
	always_comb
	begin
		power.test_sink_on = (s.qstate == srcq_pkg::Q_WINDOW); // R1 R2
		power.converter_on = (s.qstate == srcq_pkg::Q_RUN); // R5 R7
		power.battery_switch_on = (s.qstate == srcq_pkg::Q_WEAK) ||
			(s.qstate == srcq_pkg::Q_OVP); // R5 R7
		power.battery_gate_drive = (s.qstate == srcq_pkg::Q_WEAK) ||
			(s.qstate == srcq_pkg::Q_OVP); // R5 R7
	end

	// Pulses override the enable so faults always reach the host
	// The open-drain data pins only ever pull low; the enables do the work
	assign charge_status_oe = (s.pulse != '0) ||
		(s.stat_en && s.state_code == srcq_pkg::ST_CHARGING); // R9 R10 R11
	assign charge_status_o  = 1'b0;
	assign host_event_oe    = charge_status_oe; // R12
	assign host_event_o     = 1'b0;
	assign reg_rdata        = s.rdata;
	assign supply_status    = s.supply_status;
	assign load_defaults    = s.load_defaults;
	assign safety_restart   = s.load_defaults; // R17

endmodule

`default_nettype wire

// ==== src/srcq_pkg.sv ====
// Package: constants, encodings and carriers for the source qualify / status report block
package srcq_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_HZ         = 200_000_000;
	localparam int unsigned PULSE_US       = 128;
	localparam int unsigned WINDOW_MS      = 32;
	localparam int unsigned RETRY_S        = 2;
	localparam int unsigned WATCHDOG_S     = 30;
	localparam int unsigned SINK_MA        = 75;
	localparam int unsigned PULSE_CYC      = (CLK_HZ / 1_000_000) * PULSE_US;
	localparam longint unsigned WINDOW_CYC = longint'(CLK_HZ / 1_000) * WINDOW_MS;
	localparam longint unsigned RETRY_CYC  = longint'(CLK_HZ) * RETRY_S;
	localparam longint unsigned WDOG_CYC   = longint'(CLK_HZ) * WATCHDOG_S;
	localparam int unsigned CNT_W          = 36;

	// ==========================================================
	// Register 00 layout
	localparam logic [7:0] REG_CHARGE_STATE_AND_FAULT = 8'h00;
	localparam int unsigned KICK_BIT   = 7;
	localparam int unsigned STATE_LSB  = 4;
	localparam int unsigned SPARE_BIT  = 3;
	localparam int unsigned FAULT_LSB  = 0;
	localparam logic       SPARE_RESET = 1'b0;
	localparam logic       STAT_EN_RESET = 1'b1;

	// ==========================================================
	// State code field
	typedef enum logic [2:0] {
		ST_NO_SOURCE = 3'h0,
		ST_IN_READY  = 3'h1,
		ST_CHARGING  = 3'h3,
		ST_DONE      = 3'h5,
		ST_FAULT     = 3'h7
	} charge_state_code_t;

	// Fault code field
	typedef enum logic [2:0] {
		FLT_NORMAL   = 3'h0,
		FLT_THERMAL  = 3'h1,
		FLT_BAT_TEMP = 3'h2,
		FLT_WATCHDOG = 3'h3,
		FLT_SAFETY   = 3'h4,
		FLT_SUPPLY   = 3'h5,
		FLT_BATTERY  = 3'h7
	} fault_code_t;

	// Supply status field (battery/supply status register bits 7:6)
	typedef enum logic [1:0] {
		SUP_NORMAL = 2'h0,
		SUP_OVP    = 2'h1,
		SUP_WEAK   = 2'h2,
		SUP_UVLO   = 2'h3
	} supply_status_t;

	// Qualification sequencer
	typedef enum logic [2:0] {
		Q_IDLE   = 3'h0,
		Q_WINDOW = 3'h1,
		Q_RETRY  = 3'h2,
		Q_RUN    = 3'h3,
		Q_WEAK   = 3'h4,
		Q_OVP    = 3'h5
	} qual_state_t;

	// Analog comparator and charger status inputs
	typedef struct packed {
		logic supply_present;
		logic above_weak;
		logic above_ovp;
		logic other_source;
		logic charging;
		logic charge_done;
	} sense_t;

	// External event strobes from other charger blocks
	typedef struct packed {
		logic safety_timer;
		logic sleep_entry;
		logic bat_temp;
		logic bat_fault;
		logic thermal;
	} events_t;

	// Power stage controls
	typedef struct packed {
		logic test_sink_on;
		logic converter_on;
		logic battery_switch_on;
		logic battery_gate_drive;
	} power_t;

	// Register port
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Whole block state
	typedef struct packed {
		qual_state_t        qstate;
		logic [CNT_W-1:0]   timer;
		logic [CNT_W-1:0]   wdog;
		logic               wdog_run;
		logic [15:0]        pulse;
		charge_state_code_t state_code;
		fault_code_t        fault_code;
		supply_status_t     supply_status;
		logic               spare;
		logic               stat_en;
		logic               load_defaults;
		logic               present_d;
		logic               other_d;
		logic [7:0]         rdata;
		logic [5:0]         sync1;
		logic [5:0]         sync2;
	} srcq_state_t;

endpackage

// ==== dv/srcq_chk.sv ====
// Assertion checker for the source qualify and status report block
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module srcq_chk
(
	// Watched ports
	input wire logic              core_clk,
	input wire logic              nrst,
	input wire srcq_pkg::sense_t  sense,
	input wire srcq_pkg::events_t events,
	input wire logic [7:0]        reg_rdata,
	input wire srcq_pkg::power_t  power,
	input wire logic              charge_status_oe,
	input wire logic              host_event_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Attach seen at the raw pin; two sync flops and the state follow
	sequence plug_in;
		$rose(sense.supply_present);
	endsequence
	chk_plug_starts_sink: assert property (plug_in |-> ##[1:5] power.test_sink_on)
		else $error("sink not on after attach");
	chk_sink_blocks_conv: assert property (!(power.test_sink_on && power.converter_on))
		else $error("sink and converter both on");
	chk_battery_path_on: assert property (power.battery_switch_on |->
		power.battery_gate_drive && !power.converter_on)
		else $error("battery path without gate or with converter");
	chk_event_pulses: assert property ((|events) |-> ##[1:3] charge_status_oe)
		else $error("event gave no pulse");
	chk_pins_mirror: assert property (charge_status_oe == host_event_oe)
		else $error("status pins differ");
	chk_kick_reads_zero: assert property (reg_rdata[7] == 1'b0)
		else $error("kick bit read as one");
	chk_state_code_legal: assert property (reg_rdata[6:4] inside {3'h0, 3'h1, 3'h3, 3'h5, 3'h7})
		else $error("unused state code");
	chk_fault_code_legal: assert property (reg_rdata[2:0] != 3'h6)
		else $error("unused fault code");
endmodule
bind source_qualify_status_report srcq_chk srcq_chk_inst (.core_clk, .nrst, .sense, .events,
	.reg_rdata, .power, .charge_status_oe, .host_event_oe);
`default_nettype wire

// ==== dv/host_model.sv ====
// Host side model: register accesses and pull-ups on the status pins
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host model
module host_model
(
	// Clock
	input  wire logic             core_clk,
	// Register port
	output var srcq_pkg::reg_req_t reg_req,
	input  wire logic [7:0]       reg_rdata,
	// Open-drain pins seen through pull-ups
	input  wire logic             charge_status_oe,
	input  wire logic             host_event_oe,
	output wire logic             charge_status_pin,
	output wire logic             host_event_pin
);
	// Pull-ups hold the lines high unless the block pulls low
	assign charge_status_pin = charge_status_oe ? 1'b0 : 1'b1;
	assign host_event_pin    = host_event_oe ? 1'b0 : 1'b1;
	initial reg_req = '0;
	// One access held over one rising edge; released lines show stale-inverted values
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge core_clk);
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// Read register 00 once its answer has settled
	task automatic read(output logic [7:0] v);
		access(1'b0, 8'h00, 8'h00);
		repeat (2) @(negedge core_clk);
		v = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking testbench for the source qualify and status report block
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Testbench
module tb;
	logic                     core_clk;
	logic                     nrst;
	srcq_pkg::sense_t         sense;
	srcq_pkg::events_t        events;
	srcq_pkg::reg_req_t       reg_req;
	logic [7:0]               reg_rdata;
	logic                     stat_enable;
	srcq_pkg::power_t         power;
	logic                     cs_oe;
	logic                     he_oe;
	logic                     cs_pin;
	logic                     he_pin;
	srcq_pkg::supply_status_t supply_status;
	int                       fails;
	int                       cmp_count;
	int                       seed;
	int                       n;
	int                       k;
	logic [7:0]               v;
	logic [7:0]               d;
	logic [7:0]               e;
	source_qualify_status_report source_qualify_status_report_inst (.core_clk, .nrst, .sense,
		.events, .reg_req, .reg_rdata, .stat_enable, .power, .charge_status_o(),
		.charge_status_oe(cs_oe), .host_event_o(), .host_event_oe(he_oe), .supply_status,
		.load_defaults(), .safety_restart());
	host_model host_model_inst (.core_clk, .reg_req, .reg_rdata, .charge_status_oe(cs_oe),
		.host_event_oe(he_oe), .charge_status_pin(cs_pin), .host_event_pin(he_pin));
	// 200 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// Register 00 as laid out: kick reads zero, then state, spare, fault
	function automatic logic [7:0] exp_reg(input logic [2:0] st, input logic spare,
		input logic [2:0] flt);
		return {1'b0, st, spare, flt};
	endfunction
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Bounded wait for the status pin; a timeout ends the run
	task automatic wait_pin(input logic lvl, input int lim, output int c);
		c = 0;
		while (cs_pin !== lvl && c < lim)
		begin
			@(negedge core_clk);
			c++;
		end
		if (c >= lim)
		begin
			check("pin wait", {7'h0, lvl}, {7'h0, cs_pin});
			close_out();
		end
	endtask
	// Main sequence, inputs changed on falling edges
	initial
	begin
		seed = 32'hed23;
		nrst = 1'b0;
		sense = '0;
		events = '0;
		stat_enable = 1'b1;
		repeat (8) @(negedge core_clk);
		check("power in reset", 8'h00, {4'h0, power});
		check("reg00 in reset", 8'h00, reg_rdata);
		check("supply in reset", 8'h03, {6'h0, supply_status});
		nrst = 1'b1;
		// Spare bit keeps random data, kick reads zero, other addresses leave it alone
		for (n = 0; n < 12; n++)
		begin
			d = 8'($random(seed));
			host_model_inst.access(1'b1, 8'h00, d);
			host_model_inst.access(1'b1, {d[7:1], 1'b1}, ~d);
			host_model_inst.read(v);
			e = exp_reg(srcq_pkg::ST_NO_SOURCE, d[3], srcq_pkg::FLT_NORMAL);
			check("reg00", e, v);
		end
		// Every event pulses both pins with the indicator disabled; retrigger restarts
		stat_enable = 1'b0;
		for (n = 0; n < 5; n++)
		begin
			events = srcq_pkg::events_t'(5'h01 << n);
			@(negedge core_clk);
			events = '0;
			@(negedge core_clk);
			wait_pin(1'b0, 4, k);
			check("event pin", 8'h00, {7'h0, he_pin});
		end
		wait_pin(1'b1, srcq_pkg::PULSE_CYC + 4, k);
		check("pulse length", 8'h01, {7'h0, k >= srcq_pkg::PULSE_CYC - 1 &&
			k <= srcq_pkg::PULSE_CYC + 1});
		// Attach: plug-in pulse and test sink alone during the window
		stat_enable = 1'b1;
		sense.above_weak = 1'b1;
		sense.supply_present = 1'b1;
		wait_pin(1'b0, 8, k);
		repeat (2) @(negedge core_clk);
		check("window power", 8'h08, {4'h0, power});
		wait_pin(1'b1, srcq_pkg::PULSE_CYC + 8, k);
		// Weak input in the window: sink off, fault codes, one pulse, retry wait
		sense.above_weak = 1'b0;
		repeat (6) @(negedge core_clk);
		check("retry power", 8'h00, {4'h0, power});
		check("retry supply", 8'h02, {6'h0, supply_status});
		check("retry pin", 8'h00, {7'h0, he_pin});
		host_model_inst.read(v);
		e = exp_reg(srcq_pkg::ST_FAULT, d[3], srcq_pkg::FLT_SUPPLY);
		check("retry reg00", e, v);
		// A new source on the other input ends the wait early
		sense.above_weak = 1'b1;
		sense.other_source = 1'b1;
		repeat (6) @(negedge core_clk);
		check("new source power", 8'h08, {4'h0, power});
		// Removal mid-window: sink off, supply lost, another pulse
		sense.supply_present = 1'b0;
		repeat (6) @(negedge core_clk);
		check("removed power", 8'h00, {4'h0, power});
		check("removed supply", 8'h03, {6'h0, supply_status});
		check("removal pin", 8'h00, {7'h0, he_pin});
		wait_pin(1'b1, srcq_pkg::PULSE_CYC + 8, k);
		check("removal pulse", 8'h01, {7'h0, k >= srcq_pkg::PULSE_CYC - 8});
		repeat (4) @(negedge core_clk);
		check("idle pin", 8'h01, {7'h0, cs_pin});
		close_out();
	end
endmodule
`default_nettype wire
